/* core/hppm_bank.sv */
// One bank of pins: each bit picks the function route or the port route.
module hppm_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] funcSel,
  input  wire logic [WIDTH-1:0] funcOut,
  input  wire logic [WIDTH-1:0] funcOe,
  input  wire logic [WIDTH-1:0] portOut,
  input  wire logic [WIDTH-1:0] portOe,
  output logic      [WIDTH-1:0] pinOut,
  output logic      [WIDTH-1:0] pinOe
);

  // Refused while the design is built, so a bad width never reaches a netlist.
  if (WIDTH < 1) begin : g_bad_width
    $error("hppm_bank width must be at least one");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign pinOut[i] = funcSel[i] ? funcOut[i] : portOut[i];
      assign pinOe[i]  = funcSel[i] ? funcOe[i]  : portOe[i];
    end
  endgenerate

endmodule : hppm_bank

/* core/hppm_mux.sv */
module hppm_mux
  import hppm_pkg::*;
#(
  parameter int FD_W = FIRST_DATA_W,
  parameter int FC_W = FIRST_CTRL_W,
  parameter int SD_W = SECOND_DATA_W,
  parameter int SC_W = SECOND_CTRL_W
) (
  input  wire logic             clock,
  input  wire logic             rst,
  // Pin side: input, output and enable of each bank.
  input  wire logic [FD_W-1:0]  firstDataBankIn,
  output logic      [FD_W-1:0]  firstDataBankOut,
  output logic      [FD_W-1:0]  firstDataBankOe,
  input  wire logic [FC_W-1:0]  firstControlBankIn,
  output logic      [FC_W-1:0]  firstControlBankOut,
  output logic      [FC_W-1:0]  firstControlBankOe,
  input  wire logic [SD_W-1:0]  secondDataBankIn,
  output logic      [SD_W-1:0]  secondDataBankOut,
  output logic      [SD_W-1:0]  secondDataBankOe,
  input  wire logic [SC_W-1:0]  secondControlBankIn,
  output logic      [SC_W-1:0]  secondControlBankOut,
  output logic      [SC_W-1:0]  secondControlBankOe,
  // Latched configuration.
  output hppm_mode_e            modeSel,
  output logic                  multiplierOff,
  // Serial function side.
  input  wire logic             serTxd,
  output logic                  serRxd,
  input  wire logic             serRtsN,
  output logic                  serCtsN,
  input  wire logic             carrierDetectN,
  input  wire logic             ringIndicateN,
  input  wire logic             transmitterDriveEnableN,
  // FIFO function side.
  input  wire logic [7:0]       fifoDataOut,
  input  wire logic             fifoDataOe,
  output logic      [7:0]       fifoDataIn,
  input  wire logic             receiveDataAvailableN,
  input  wire logic             transmitSpaceAvailableN,
  output logic                  fifoReadN,
  output logic                  fifoWrite,
  // FIFO and SPI shared handshake.
  input  wire logic             transferRequestN,
  input  wire logic             transferAcknowledgeN,
  // SPI function side.
  output logic                  spiSclk,
  output logic                  slaveSerialIn,
  input  wire logic             slaveSerialOut,
  output logic                  spiCs,
  // General-purpose port side, one set per bank.
  input  wire logic [FD_W-1:0]  fdPortOut,
  input  wire logic [FD_W-1:0]  fdPortOe,
  output logic      [FD_W-1:0]  fdPortIn,
  input  wire logic [FC_W-1:0]  fcPortOut,
  input  wire logic [FC_W-1:0]  fcPortOe,
  output logic      [FC_W-1:0]  fcPortIn,
  input  wire logic [SD_W-1:0]  sdPortOut,
  input  wire logic [SD_W-1:0]  sdPortOe,
  output logic      [SD_W-1:0]  sdPortIn,
  input  wire logic [SC_W-1:0]  scPortOut,
  input  wire logic [SC_W-1:0]  scPortOe,
  output logic      [SC_W-1:0]  scPortIn
);

  // The first banks carry fixed bit positions, so only eight bits are served.
  if (FD_W != 8 || FC_W != 8) begin : g_bad_first
    $error("hppm_mux first banks must be eight bits wide");
  end
  if (SD_W < 1 || SC_W < 1) begin : g_bad_second
    $error("hppm_mux second banks need at least one bit");
  end

  hppm_mode_e mode_reg;
  logic       multOff_reg;
  logic       inReset_reg;

  // Straps are read while reset is held, so the mode pins can turn into
  // outputs right after release without corrupting the choice.
  wire [1:0]  strapBits = {firstControlBankIn[STRAP_MODE_HI],
                           firstControlBankIn[STRAP_MODE_LO]};
  wire        strapSpi  = (strapBits == STRAP_SPI);
  wire        strapFifo = (strapBits == STRAP_FIFO);
  hppm_mode_e strapMode;
  assign strapMode = strapSpi  ? HPPM_SPI  :
                     strapFifo ? HPPM_FIFO : HPPM_SERIAL;

  always_ff @(posedge clock) begin
    inReset_reg <= rst;
    if (rst) begin
      mode_reg    <= strapMode;
      multOff_reg <= firstControlBankIn[STRAP_CLK_BIT];
    end // Held until the next reset.
  end

  assign modeSel       = mode_reg;
  assign multiplierOff = multOff_reg;

  wire isSer  = (mode_reg == HPPM_SERIAL);
  wire isFifo = (mode_reg == HPPM_FIFO);
  wire isSpi  = (mode_reg == HPPM_SPI);
  // During reset every pin is an undriven port so the straps can be read.
  wire active = !inReset_reg && !rst;

  logic [FD_W-1:0] fdSel;
  logic [FD_W-1:0] fdFunc;
  logic [FD_W-1:0] fdFuncOe;
  logic [FC_W-1:0] fcSel;
  logic [FC_W-1:0] fcFunc;
  logic [FC_W-1:0] fcFuncOe;

  always_comb begin
    fdSel    = '0;
    fdFunc   = '0;
    fdFuncOe = '0;
    fcSel    = '0;
    fcFunc   = '0;
    fcFuncOe = '0;
    case (mode_reg)
      HPPM_SERIAL: begin
        fdSel[SER_TXD_BIT]    = 1'b1;
        fdFunc[SER_TXD_BIT]   = serTxd;
        fdFuncOe[SER_TXD_BIT] = 1'b1;
        fdSel[SER_RXD_BIT]    = 1'b1;
        fdSel[SER_RTS_BIT]    = 1'b1;
        fdFunc[SER_RTS_BIT]   = serRtsN;
        fdFuncOe[SER_RTS_BIT] = 1'b1;
        fdSel[SER_CTS_BIT]    = 1'b1;
        fdSel[SER_DCD_BIT]    = 1'b1;
        fdFunc[SER_DCD_BIT]   = carrierDetectN;
        fdFuncOe[SER_DCD_BIT] = 1'b1;
        fdSel[SER_RI_BIT]     = 1'b1;
        fdFunc[SER_RI_BIT]    = ringIndicateN;
        fdFuncOe[SER_RI_BIT]  = 1'b1;
        fcSel[SER_TRANSMITTER_DRIVE_ENABLE_N_BIT]    = 1'b1;
        fcFunc[SER_TRANSMITTER_DRIVE_ENABLE_N_BIT]   = transmitterDriveEnableN;
        fcFuncOe[SER_TRANSMITTER_DRIVE_ENABLE_N_BIT] = 1'b1;
      end
      HPPM_FIFO: begin
        fdSel    = '1;
        fdFunc   = fifoDataOut;
        fdFuncOe = {FD_W{fifoDataOe}};
        fcSel[FIFO_RXF_BIT]    = 1'b1;
        fcFunc[FIFO_RXF_BIT]   = receiveDataAvailableN;
        fcFuncOe[FIFO_RXF_BIT] = 1'b1;
        fcSel[FIFO_TXE_BIT]    = 1'b1;
        fcFunc[FIFO_TXE_BIT]   = transmitSpaceAvailableN;
        fcFuncOe[FIFO_TXE_BIT] = 1'b1;
        fcSel[FIFO_RD_BIT]     = 1'b1;
        fcSel[FIFO_WR_BIT]     = 1'b1;
        fcSel[XFER_REQ_BIT]    = 1'b1;
        fcFunc[XFER_REQ_BIT]   = transferRequestN;
        fcFuncOe[XFER_REQ_BIT] = 1'b1;
        fcSel[XFER_ACK_BIT]    = 1'b1;
        fcFunc[XFER_ACK_BIT]   = transferAcknowledgeN;
        fcFuncOe[XFER_ACK_BIT] = 1'b1;
      end
      HPPM_SPI: begin
        fdSel[SPI_SCLK_BIT]    = 1'b1;
        fdSel[SPI_SDI_BIT]     = 1'b1;
        fdSel[SPI_SDO_BIT]     = 1'b1;
        fdFunc[SPI_SDO_BIT]    = slaveSerialOut;
        fdFuncOe[SPI_SDO_BIT]  = 1'b1;
        fdSel[SPI_CS_BIT]      = 1'b1;
        // The unavailable bit is claimed and left undriven.
        fdSel[SPI_NA_BIT]      = 1'b1;
        fcSel[XFER_REQ_BIT]    = 1'b1;
        fcFunc[XFER_REQ_BIT]   = transferRequestN;
        fcFuncOe[XFER_REQ_BIT] = 1'b1;
        fcSel[XFER_ACK_BIT]    = 1'b1;
        fcFunc[XFER_ACK_BIT]   = transferAcknowledgeN;
        fcFuncOe[XFER_ACK_BIT] = 1'b1;
      end
      default: begin
        fdSel = '0;
        fcSel = '0;
      end
    endcase
  end

  wire [FD_W-1:0] fdSelAct = active ? fdSel : '0;
  wire [FC_W-1:0] fcSelAct = active ? fcSel : '0;
  wire [FD_W-1:0] fdPOe    = active ? fdPortOe : '0;
  wire [FC_W-1:0] fcPOe    = active ? fcPortOe : '0;

  hppm_bank #(.WIDTH(FD_W)) u_first_data (
    .funcSel (fdSelAct),
    .funcOut (fdFunc),
    .funcOe  (fdFuncOe),
    .portOut (fdPortOut),
    .portOe  (fdPOe),
    .pinOut  (firstDataBankOut),
    .pinOe   (firstDataBankOe)
  );

  hppm_bank #(.WIDTH(FC_W)) u_first_ctrl (
    .funcSel (fcSelAct),
    .funcOut (fcFunc),
    .funcOe  (fcFuncOe),
    .portOut (fcPortOut),
    .portOe  (fcPOe),
    .pinOut  (firstControlBankOut),
    .pinOe   (firstControlBankOe)
  );

  // Second banks have no host function in any mode.
  assign secondDataBankOut    = sdPortOut;
  assign secondDataBankOe     = active ? sdPortOe : '0;
  assign secondControlBankOut = scPortOut;
  assign secondControlBankOe  = active ? scPortOe : '0;
  assign sdPortIn             = secondDataBankIn;
  assign scPortIn             = secondControlBankIn;

  // Function inputs read the pin only when routed; port inputs read zero then.
  assign serRxd        = isSer  && fdSelAct[SER_RXD_BIT] && firstDataBankIn[SER_RXD_BIT];
  assign serCtsN       = !(isSer && fdSelAct[SER_CTS_BIT]) || firstDataBankIn[SER_CTS_BIT];
  assign fifoDataIn    = (isFifo && active) ? firstDataBankIn : 8'h00;
  assign fifoReadN     = !(isFifo && active) || firstControlBankIn[FIFO_RD_BIT];
  assign fifoWrite     = isFifo && active && firstControlBankIn[FIFO_WR_BIT];
  assign spiSclk       = isSpi && active && firstDataBankIn[SPI_SCLK_BIT];
  assign slaveSerialIn = isSpi && active && firstDataBankIn[SPI_SDI_BIT];
  assign spiCs         = isSpi && active && firstDataBankIn[SPI_CS_BIT];
  assign fdPortIn      = firstDataBankIn & ~fdSelAct;
  assign fcPortIn      = firstControlBankIn & ~fcSelAct;

endmodule : hppm_mux

/* core/hppm_pkg.sv */
package hppm_pkg;

  // Interface modes, one-hot.
  typedef enum logic [2:0] {
    HPPM_SERIAL = 3'b001,
    HPPM_FIFO   = 3'b010,
    HPPM_SPI    = 3'b100
  } hppm_mode_e;

  localparam int FIRST_DATA_W   = 8;
  localparam int FIRST_CTRL_W   = 8;
  localparam int SECOND_DATA_W  = 8;
  localparam int SECOND_CTRL_W  = 4;

  // Serial mode, first data bank.
  localparam int SER_TXD_BIT    = 0;
  localparam int SER_RXD_BIT    = 1;
  localparam int SER_RTS_BIT    = 2;
  localparam int SER_CTS_BIT    = 3;
  localparam int SER_DCD_BIT    = 6;
  localparam int SER_RI_BIT     = 7;
  // Serial mode, first control bank.
  localparam int SER_TRANSMITTER_DRIVE_ENABLE_N_BIT  = 0;

  // FIFO mode, first control bank.
  localparam int FIFO_RXF_BIT   = 0;
  localparam int FIFO_TXE_BIT   = 1;
  localparam int FIFO_RD_BIT    = 2;
  localparam int FIFO_WR_BIT    = 3;

  // FIFO and SPI modes, first control bank.
  localparam int XFER_REQ_BIT   = 4;
  localparam int XFER_ACK_BIT   = 5;

  // SPI mode, first data bank.
  localparam int SPI_SCLK_BIT   = 0;
  localparam int SPI_SDI_BIT    = 1;
  localparam int SPI_SDO_BIT    = 2;
  localparam int SPI_CS_BIT     = 3;
  localparam int SPI_NA_BIT     = 4;

  // Straps on the first control bank.
  localparam int STRAP_MODE_HI  = 6;
  localparam int STRAP_MODE_LO  = 5;
  localparam int STRAP_CLK_BIT  = 7;

  localparam logic [1:0] STRAP_SERIAL_A = 2'h3;
  localparam logic [1:0] STRAP_SPI      = 2'h2;
  localparam logic [1:0] STRAP_FIFO     = 2'h1;

endpackage : hppm_pkg

/* testbench/hppm_host_model.sv */
// External controller at one bank: resolves each pin from both drivers.
module hppm_host_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] devOut,
  input  wire logic [W-1:0] devOe,
  input  wire logic [W-1:0] hostOut,
  input  wire logic [W-1:0] hostOe,
  input  wire logic [W-1:0] pull,
  output logic      [W-1:0] pin
);
  // A released line falls to its board resistor level, never to the last driven value.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin[i] = devOe[i] ? devOut[i] : (hostOe[i] ? hostOut[i] : pull[i]);
    end
  end
endmodule : hppm_host_model

/* testbench/hppm_mux_chk.sv */
module hppm_mux_chk
  import hppm_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] firstDataBankIn,
  input wire logic [7:0] firstDataBankOut,
  input wire logic [7:0] firstDataBankOe,
  input wire logic [7:0] firstControlBankIn,
  input wire logic [7:0] firstControlBankOut,
  input wire logic [7:0] firstControlBankOe,
  input wire logic [7:0] secondDataBankOut,
  input wire logic [7:0] secondDataBankOe,
  input wire logic [7:0] sdPortOut,
  input wire logic [7:0] sdPortOe,
  input wire hppm_mode_e modeSel,
  input wire logic       multiplierOff,
  input wire logic       serTxd,
  input wire logic       serRxd,
  input wire logic       transmitterDriveEnableN,
  input wire logic [7:0] fifoDataIn,
  input wire logic       receiveDataAvailableN,
  input wire logic       fifoWrite,
  input wire logic       transferRequestN,
  input wire logic       transferAcknowledgeN,
  input wire logic       spiSclk,
  input wire logic       slaveSerialOut
);
  logic [1:0] liveCnt_reg;
  logic       live;
  logic       inSer;
  logic       inFifo;
  logic       inSpi;
  // Pins stay released briefly after reset, so routing is judged only once settled.
  assign live   = liveCnt_reg == 2'h3;
  assign inSer  = live && modeSel == HPPM_SERIAL;
  assign inFifo = live && modeSel == HPPM_FIFO;
  assign inSpi  = live && modeSel == HPPM_SPI;

  always_ff @(posedge clock) begin
    if (rst) begin
      liveCnt_reg <= 2'h0;
    end else if (!live) begin
      liveCnt_reg <= liveCnt_reg + 2'h1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_ser_data_route: assert property (inSer |->
    firstDataBankOut[0] == serTxd && firstDataBankOe[0] && serRxd == firstDataBankIn[1])
    else $error("Serial data pins misrouted.");
  a_ser_drive_en: assert property (inSer |->
    firstControlBankOut[0] == transmitterDriveEnableN && firstControlBankOe[0])
    else $error("Drive enable pin misrouted.");
  a_fifo_data_in: assert property (inFifo |-> fifoDataIn == firstDataBankIn)
    else $error("FIFO data input misrouted.");
  a_fifo_flags: assert property (inFifo |->
    firstControlBankOut[0] == receiveDataAvailableN && fifoWrite == firstControlBankIn[3])
    else $error("FIFO flag or strobe misrouted.");
  a_xfer_handshake: assert property ((inFifo || inSpi) |->
    firstControlBankOut[5:4] == {transferAcknowledgeN, transferRequestN}
    && firstControlBankOe[5:4] == 2'h3) else $error("Transfer handshake misrouted.");
  a_spi_route: assert property (inSpi |-> spiSclk == firstDataBankIn[0]
    && firstDataBankOut[2] == slaveSerialOut && !firstDataBankOe[4])
    else $error("SPI pins misrouted.");
  a_second_port: assert property (live |-> secondDataBankOe == sdPortOe
    && (secondDataBankOut & sdPortOe) == (sdPortOut & sdPortOe))
    else $error("Second data bank not a plain port.");
  a_mode_decode: assert property ($fell(rst) |-> modeSel ==
    ($past(firstControlBankIn[6:5]) == 2'h1 ? HPPM_FIFO :
     $past(firstControlBankIn[6:5]) == 2'h2 ? HPPM_SPI : HPPM_SERIAL))
    else $error("Mode straps decoded wrongly.");
  a_clock_strap: assert property ($fell(rst) |->
    multiplierOff == $past(firstControlBankIn[7])) else $error("Clock strap latched wrongly.");
  a_mode_hold: assert property (!$past(rst) |-> $stable(modeSel))
    else $error("Mode changed outside reset.");
endmodule : hppm_mux_chk

bind hppm_mux hppm_mux_chk u_chk (.*);

/* testbench/test_host_port_pin_function_mux.sv */
module test_host_port_pin_function_mux
  import hppm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst, serTxd, serRxd, serRtsN, serCtsN, carrierDetectN, ringIndicateN,
    transmitterDriveEnableN, fifoDataOe, receiveDataAvailableN, transmitSpaceAvailableN,
    fifoReadN, fifoWrite, transferRequestN, transferAcknowledgeN, spiSclk, slaveSerialIn,
    slaveSerialOut, spiCs, multiplierOff;
  logic [7:0] firstDataBankIn, firstDataBankOut, firstDataBankOe, firstControlBankIn,
    firstControlBankOut, firstControlBankOe, secondDataBankIn, secondDataBankOut,
    secondDataBankOe, fifoDataOut, fifoDataIn, fdPortOut, fdPortOe, fdPortIn, fcPortOut,
    fcPortOe, fcPortIn, sdPortOut, sdPortOe, sdPortIn, fdHo, fdHe, fcHo, fcHe, fcPull,
    sdHo, sdHe;
  logic [3:0] secondControlBankIn, secondControlBankOut, secondControlBankOe, scPortOut,
    scPortOe, scPortIn, scHo, scHe;
  hppm_mode_e modeSel;
  int errors, samplesChecked;

  hppm_mux u_dut (.*);
  // Lines outside the first control bank fall to the inverse of what the host last drove.
  hppm_host_model #(.W(8)) u_fd (.devOut(firstDataBankOut), .devOe(firstDataBankOe),
    .hostOut(fdHo), .hostOe(fdHe), .pull(~fdHo), .pin(firstDataBankIn));
  hppm_host_model #(.W(8)) u_fc (.devOut(firstControlBankOut), .devOe(firstControlBankOe),
    .hostOut(fcHo), .hostOe(fcHe), .pull(fcPull), .pin(firstControlBankIn));
  hppm_host_model #(.W(8)) u_sd (.devOut(secondDataBankOut), .devOe(secondDataBankOe),
    .hostOut(sdHo), .hostOe(sdHe), .pull(~sdHo), .pin(secondDataBankIn));
  hppm_host_model #(.W(4)) u_sc (.devOut(secondControlBankOut), .devOe(secondControlBankOe),
    .hostOut(scHo), .hostOe(scHe), .pull(~scHo), .pin(secondControlBankIn));

  always #20 clock = ~clock;

  task tick;
    @(posedge clock);
    #1;
  endtask : tick

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samplesChecked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task closeOut;
    if (errors == 0 && samplesChecked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : closeOut

  // The argument holds the clock strap and the two mode straps, high bit first.
  task startUp(input logic [2:0] s);
    hppm_mode_e expMode;
    rst = 1'b1;
    fcPull = {s, 5'h1f};
    {fdHe, fcHe, sdHe, scHe, fdPortOe, fcPortOe, sdPortOe, scPortOe} = '0;
    repeat (5) tick();
    rst = 1'b0;
    repeat (3) tick();
    expMode = (s[1:0] == 2'h1) ? HPPM_FIFO : (s[1:0] == 2'h2) ? HPPM_SPI : HPPM_SERIAL;
    chk("mode", expMode, modeSel);
    chk("multiplier", s[2], multiplierOff);
  endtask : startUp

  task testSerial(input logic [2:0] s);
    startUp(s);
    {serTxd, serRtsN, carrierDetectN, ringIndicateN, transmitterDriveEnableN} = 5'b10100;
    fdHo = 8'h02;
    fdHe = 8'h0a;
    {fdPortOut, fdPortOe} = {8'h30, 8'h30};
    tick();
    chk("serial pins", 8'h71, firstDataBankOut & 8'hf5);
    chk("serial oe", 8'hf5, firstDataBankOe & 8'hf5);
    chk("serial in", 8'h01, {serCtsN, serRxd});
    chk("drive enable", 8'h02, {firstControlBankOe[0], firstControlBankOut[0]});
  endtask : testSerial

  task testFifo;
    startUp(3'b001);
    {fifoDataOut, fifoDataOe} = {8'ha5, 1'b1};
    {receiveDataAvailableN, transmitSpaceAvailableN} = 2'h1;
    {transferRequestN, transferAcknowledgeN} = 2'h1;
    {fcHo, fcHe} = {8'h08, 8'h0c};
    tick();
    chk("fifo out", 8'ha5, firstDataBankOut);
    chk("fifo oe", 8'hff, firstDataBankOe);
    chk("fifo ctl", 8'h22, firstControlBankOut & 8'h33);
    chk("fifo ctl oe", 8'h33, firstControlBankOe & 8'h3f);
    chk("strobes", 8'h01, {fifoReadN, fifoWrite});
    {fifoDataOe, fdHo, fdHe} = {1'b0, 8'h3c, 8'hff};
    tick();
    chk("fifo in", 8'h3c, fifoDataIn);
  endtask : testFifo

  task testSpiPorts;
    startUp(3'b010);
    {fdHo, fdHe, slaveSerialOut} = {8'h09, 8'h0b, 1'b1};
    {transferRequestN, transferAcknowledgeN} = 2'b10;
    {fdPortOut, fdPortOe, fcPortOut, fcPortOe} = {8'h10, 8'h10, 8'h80, 8'h80};
    {sdPortOut, sdPortOe, sdHo, sdHe} = {8'h5a, 8'hf0, 8'h0f, 8'h0f};
    {scPortOut, scPortOe, scHo, scHe} = {4'h9, 4'h3, 4'hc, 4'hc};
    tick();
    chk("spi in", 8'h05, {spiSclk, slaveSerialIn, spiCs});
    chk("spi oe", 8'h04, firstDataBankOe & 8'h14);
    chk("spi out", 8'h04, firstDataBankOut & 8'h04);
    chk("spi handshake", 8'h10, firstControlBankOut & 8'h30);
    chk("second data", 8'h5f, sdPortIn);
    chk("second data oe", 8'hf0, secondDataBankOe);
    chk("second ctl", 8'h0d, scPortIn);
    chk("ctl port", 8'h80, firstControlBankOut & firstControlBankOe & 8'h80);
    chk("spi port in", 8'he0, fdPortIn);
    chk("ctl port in", 8'hcf, fcPortIn);
    fcPull = 8'h3f;
    repeat (4) tick();
    chk("mode held", HPPM_SPI, modeSel);
  endtask : testSpiPorts

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    fcPull = 8'hff;
    errors = 0;
    samplesChecked = 0;
    {serTxd, serRtsN, carrierDetectN, ringIndicateN, transmitterDriveEnableN, fifoDataOe,
      receiveDataAvailableN, transmitSpaceAvailableN, transferRequestN, transferAcknowledgeN,
      slaveSerialOut, fifoDataOut, fdPortOut, fdPortOe, fcPortOut, fcPortOe, sdPortOut,
      sdPortOe, scPortOut, scPortOe, fdHo, fdHe, fcHo, fcHe, sdHo, sdHe, scHo, scHe} = '0;
    testSerial(3'b011);
    testSerial(3'b100);
    testFifo();
    testSpiPorts();
    startUp(3'b110);
    closeOut();
  end

  // The whole sequence needs well under a hundred cycles.
  initial begin
    #20000;
    errors++;
    closeOut();
  end
endmodule : test_host_port_pin_function_mux
